// ### dv/dcrc_controller_tb.sv
// self-checking bench of the dram controller with a dram model
// assumes the controller takes one request at a time and pulses rsp_valid
`timescale 1ns/1ns
`default_nettype none
`define dcrc_chk(got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("Error at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module dcrc_controller_tb;
  import dcrc_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [REQ_ADDR_WIDTH-1:0] req_addr = '0;
  logic req_wdata = 1'b0;
  logic req_ready, rsp_valid, rsp_data, ras_n, cas_n, we_n, d, q;
  logic [ADDR_WIDTH-1:0] muxed_address_lines;
  int n_fail = 0;
  int n_checks = 0;
  int n_viol, n_refresh, n_exp, t0;
  int cyc = 0;
  logic sb [bit [21:0]];
  bit [21:0] addrs [$];
  bit [21:0] corner [4] = '{22'h000000, 22'h3fffff, 22'h3ff800, 22'h0007ff};
  always #10 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  dcrc_controller i_dcrc_controller(.clk(clk), .reset_n(reset_n),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .muxed_address_lines(muxed_address_lines), .d(d), .q(q));
  dcrc_dram_model i_dcrc_dram_model(.ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .muxed_address_lines(muxed_address_lines), .d(d), .q(q),
    .n_viol(n_viol), .n_refresh(n_refresh));
  function automatic logic expect_bit(bit [21:0] a);
    return sb[a];
  endfunction
  task automatic wrap_up();
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic access(input logic w, input bit [21:0] a, input logic v);
    int i;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= v;
    // ready settles between edges; the take is the rise after it is seen
    @(negedge clk);
    for (i = 0; i < 64 && req_ready !== 1'b1; i++) @(negedge clk);
    if (i == 64)
    begin
      n_fail++;
      wrap_up();
    end
    @(posedge clk);
    req_valid <= 1'b0;
    for (i = 0; i < 40; i++)
    begin
      @(posedge clk);
      #1;
      if (rsp_valid === 1'b1) break;
    end
    if (i == 40)
    begin
      n_fail++;
      wrap_up();
    end
    else if (w)
      sb[a] = v;
    else
      `dcrc_chk(rsp_data, expect_bit(a))
  endtask
  initial
  begin
    void'($urandom(32'hde7f));
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    t0 = cyc + 1;
    // address corners, written then read back to back
    foreach (corner[k]) access(1'b1, corner[k], k[0]);
    foreach (corner[k]) access(1'b0, corner[k], 1'b0);
    foreach (corner[k]) addrs.push_back(corner[k]);
    for (int n = 0; n < 150; n++)
    begin
      if ($urandom_range(1) == 1)
      begin
        addrs.push_back(22'($urandom()));
        access(1'b1, addrs[addrs.size() - 1], 1'($urandom()));
      end
      else if ($urandom_range(3) == 0)
        access(1'b1, addrs[$urandom_range(addrs.size() - 1)], 1'($urandom()));
      else
        access(1'b0, addrs[$urandom_range(addrs.size() - 1)], 1'b0);
    end
    // idle stretch lets plain refreshes run alone
    repeat (2000) @(posedge clk);
    foreach (addrs[k]) access(1'b0, addrs[k], 1'b0);
    `dcrc_chk(n_viol, 0)
    n_exp = (cyc - t0) / REFRESH_INTERVAL_CYC;
    `dcrc_chk(n_refresh >= n_exp - 1 && n_refresh <= n_exp, 1'b1)
    wrap_up();
  end
endmodule
`default_nettype wire

// ### dv/dcrc_dram_model.sv
// behavioural 4M x 1 page-mode dram seen at its pins
// assumes strobes from the controller; counts controller timing faults
`timescale 1ns/1ns
`default_nettype none
module dcrc_dram_model
  import dcrc_pkg::*;
(
  // strobes and address
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [ADDR_WIDTH-1:0] muxed_address_lines,
  // data
  input wire logic d,
  output logic q,
  // observation
  output int n_viol,
  output int n_refresh
);
  logic mem [bit [21:0]];
  logic [10:0] row = '0;
  logic [10:0] col = '0;
  logic [9:0] refresh_row = '0;
  logic cbr = 1'b0;
  logic read_open = 1'b0;
  logic col_seen = 1'b0;
  realtime t_ras = 0;
  realtime t_cas = 0;
  realtime t_we = -100;
  realtime t_we_hi = 0;
  initial
  begin
    q = 1'b0;
    n_viol = 0;
    n_refresh = 0;
  end
  always @(negedge ras_n)
  begin
    t_ras = $realtime;
    col_seen = 1'b0;
    cbr = !cas_n;
    if (!cas_n)
    begin
      // address ignored, row from the inner counter
      refresh_row = refresh_row + 10'h1;
      n_refresh++;
      if (t_ras - t_cas < 5 || !we_n) n_viol++;
      if (t_ras - t_we_hi < 10) n_viol++;
    end
    else
      row = muxed_address_lines;
  end
  always @(negedge cas_n)
  begin
    t_cas = $realtime;
    if (!ras_n && !cbr)
    begin
      col = muxed_address_lines;
      col_seen = 1'b1;
      read_open = we_n;
      if (!we_n)
        mem[{row, col}] = d;
      else
        q = mem.exists({row, col}) ? mem[{row, col}] : ~q;
    end
  end
  always @(negedge we_n)
  begin
    t_we = $realtime;
    if (read_open) n_viol++;
    if (!ras_n && !cas_n && read_open)
    begin
      if (t_we - t_cas < 20 || t_we - t_ras < 60) q = 1'bx;
      mem[{row, col}] = d;
    end
    if (cbr && !ras_n && t_we - t_ras < 10) n_viol++;
  end
  always @(posedge we_n) t_we_hi = $realtime;
  always @(posedge cas_n)
  begin
    if ($realtime - t_we < 20) n_viol++;
    if (cbr && $realtime - t_ras < 15) n_viol++;
    read_open = 1'b0;
    // released output shows no stale value
    q = ~q;
  end
  always @(posedge ras_n)
  begin
    if ($realtime - t_we < 20) n_viol++;
    if (!cbr && !col_seen) refresh_row = row[9:0];
    read_open = 1'b0;
  end
endmodule
`default_nettype wire

// ### inc/dcrc_pkg.sv
// timing constants and state codes of the dram cycle and refresh controller
// assumes a single 50 MHz clock drives every flip-flop of the controller
package dcrc_pkg;

  localparam int CLK_PERIOD_NS = 20;
  localparam int ADDR_WIDTH = 11;
  localparam int REQ_ADDR_WIDTH = 22;
  localparam int SYNC_STAGES = 2;

  // least times in ns; counts round up, never below one cycle
  localparam int RAS_PRECHARGE_NS = 45;
  localparam int RAS_PULSE_NS = 60;
  localparam int RAS_TO_CAS_NS = 20;
  localparam int CAS_ACCESS_NS = 20;
  localparam int WRITE_TO_COLUMN_LEAD_NS = 20;
  localparam int REFRESH_COLUMN_SETUP_NS = 5;
  localparam int REFRESH_COLUMN_HOLD_NS = 15;
  localparam int REFRESH_WRITE_HIGH_SETUP_NS = 10;
  localparam int COUNTER_TEST_COLUMN_PRECHARGE_NS = 30;

  // refresh period in ms over the rows of the array
  localparam int REFRESH_PERIOD_MS = 16;
  localparam int REFRESH_ROWS = 1024;

  function automatic int dcrc_min_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int RAS_PRECHARGE_CYC = dcrc_min_cycles(RAS_PRECHARGE_NS);
  localparam int RAS_PULSE_CYC = dcrc_min_cycles(RAS_PULSE_NS);
  localparam int RAS_TO_CAS_CYC = dcrc_min_cycles(RAS_TO_CAS_NS);
  localparam int CAS_ACCESS_CYC = dcrc_min_cycles(CAS_ACCESS_NS);
  localparam int WRITE_LEAD_CYC = dcrc_min_cycles(WRITE_TO_COLUMN_LEAD_NS);
  localparam int CBR_SETUP_CYC = dcrc_min_cycles(REFRESH_COLUMN_SETUP_NS);
  localparam int CBR_HOLD_CYC = dcrc_min_cycles(REFRESH_COLUMN_HOLD_NS);
  localparam int CBR_WE_SETUP_CYC =
    dcrc_min_cycles(REFRESH_WRITE_HIGH_SETUP_NS);
  localparam int COUNTER_TEST_CYC =
    dcrc_min_cycles(COUNTER_TEST_COLUMN_PRECHARGE_NS);

  // row phase: one cycle of row hold before the column is put out
  localparam int ROW_CYC = RAS_TO_CAS_CYC + 1;
  // column phase covers the ras pulse, access and the data synchroniser
  localparam int COL_CYC = RAS_PULSE_CYC + CAS_ACCESS_CYC + SYNC_STAGES;
  // refresh spacing in cycles, rounded down
  localparam int REFRESH_INTERVAL_CYC =
    (REFRESH_PERIOD_MS * 1000000 / CLK_PERIOD_NS) / REFRESH_ROWS;

  localparam logic [3:0] CNT_ROW = 4'(ROW_CYC);
  localparam logic [3:0] CNT_COL = 4'(COL_CYC);
  localparam logic [3:0] CNT_PRE = 4'(RAS_PRECHARGE_CYC);
  localparam logic [3:0] CNT_RAS = 4'(RAS_PULSE_CYC);
  localparam logic [3:0] CNT_CBR_SETUP = 4'(CBR_SETUP_CYC);

  typedef enum logic [7:0] {
    DCRC_IDLE = 8'h01,
    DCRC_ACT = 8'h02,
    DCRC_ROW = 8'h04,
    DCRC_COL = 8'h08,
    DCRC_PRE = 8'h10,
    DCRC_CBR_SETUP = 8'h20,
    DCRC_CBR_RAS = 8'h40,
    DCRC_HIDDEN_PRE = 8'h80
  } dcrc_state_type;

endpackage

// ### rtl/dcrc_controller.sv
// host-side controller for an asynchronous 4M x 1 page-mode dram
// assumes the dram pins are wired directly; q comes from outside the clock
// Contract
// RULE_01: a read keeps write enable high past column or row strobe rise.
// RULE_02: data is taken at column fall in early write, else at write fall.
// RULE_03: write low by column fall is an early write; output stays off.
// RULE_04: a late enough write fall is a read-write cycle, read data first.
// RULE_05: write timing meeting neither case leaves the output unknown.
// RULE_06: both strobes stay low at least 20 ns after write enable falls.
// RULE_07: ras-only refresh uses address bits 0 to 9, not write or bit 10.
// RULE_08: cas-before-ras refresh ignores all address lines.
// RULE_09: cas-before-ras: column falls 5 ns before row, holds 15 ns after.
// RULE_10: normal cas-before-ras keeps write high 10 ns around row fall.
// RULE_11: test mode is entered with write enable low 10 ns around row fall.
// RULE_12: counter test keeps column strobe high 30 or 40 ns between pulses.
// RULE_13: every row is refreshed within 16 ms (128 ms low-power).
// RULE_14: 11 address lines carry the row at row fall, column at column fall.
// RULE_15: read data is valid only while the column strobe is low.
// RULE_16: hidden refresh keeps column strobe low while the row strobe cycles.
`timescale 1ns/1ns
`default_nettype none
module dcrc_controller
  import dcrc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // user request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [REQ_ADDR_WIDTH-1:0] req_addr,
  input wire logic req_wdata,
  output logic req_ready,
  // user response
  output logic rsp_valid,
  output logic rsp_data,
  // dram pins
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [ADDR_WIDTH-1:0] muxed_address_lines,
  output logic d,
  input wire logic q
);

  dcrc_state_type state;
  logic [3:0] cnt;
  logic last;
  logic is_write;
  logic [ADDR_WIDTH-1:0] col_addr;
  logic refresh_tick;
  logic refresh_pending;
  logic q_meta;
  logic q_sync;
  logic [7:0] pending_age;

  assign last = (cnt == 4'h1);
  assign req_ready = (state == DCRC_IDLE) && !refresh_pending;

  dcrc_refresh_timer u_timer (
    .clk(clk),
    .reset_n(reset_n),
    .refresh_tick(refresh_tick)
  );

  // q is asynchronous to clk; only q_sync is read
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q_meta <= 1'b0;
      q_sync <= 1'b0;
    end
    else
    begin
      q_meta <= q;
      q_sync <= q_meta;
    end
  end

  // a tick in the last cycle of DCRC_CBR_RAS is kept; one in an earlier cycle of it is cleared
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      refresh_pending <= 1'b0;
    else if (refresh_tick)
      refresh_pending <= 1'b1; // RULE_13
    else if (state == DCRC_CBR_RAS)
      refresh_pending <= 1'b0;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= DCRC_IDLE;
      cnt <= 4'h0;
      is_write <= 1'b0;
      col_addr <= '0;
      ras_n <= 1'b1;
      cas_n <= 1'b1;
      we_n <= 1'b1;
      muxed_address_lines <= '0;
      d <= 1'b0;
    end
    else
    begin
      cnt <= (cnt != 4'h0) ? cnt - 4'h1 : 4'h0;
      unique case (state)
        DCRC_IDLE:
        begin
          if (refresh_pending)
          begin
            // we_n already high for the setup before row fall
            cas_n <= 1'b0; // RULE_09
            cnt <= CNT_CBR_SETUP;
            state <= DCRC_CBR_SETUP;
          end
          else if (req_valid)
          begin
            muxed_address_lines <= // RULE_14
              req_addr[2*ADDR_WIDTH-1:ADDR_WIDTH];
            col_addr <= req_addr[ADDR_WIDTH-1:0];
            is_write <= req_write;
            d <= req_wdata;
            // write enable falls before the row, so the cycle is early write
            we_n <= !req_write; // RULE_11
            state <= DCRC_ACT;
          end
        end
        DCRC_ACT:
        begin
          ras_n <= 1'b0; // RULE_14
          cnt <= CNT_ROW;
          state <= DCRC_ROW;
        end
        DCRC_ROW:
        begin
          muxed_address_lines <= col_addr; // RULE_14
          if (last)
          begin
            cas_n <= 1'b0;
            cnt <= CNT_COL;
            state <= DCRC_COL;
          end
        end
        DCRC_COL:
        begin
          if (last)
          begin
            // for a write both strobes rise together, well after the write fell
            cnt <= CNT_PRE; // RULE_06
            if (refresh_pending && !is_write)
            begin
              ras_n <= 1'b1; // RULE_16
              state <= DCRC_HIDDEN_PRE;
            end
            else
            begin
              ras_n <= 1'b1;
              cas_n <= 1'b1;
              state <= DCRC_PRE;
            end
            // we_n rises with or after the strobes
            we_n <= 1'b1; // RULE_01
          end
        end
        DCRC_HIDDEN_PRE:
        begin
          if (last)
          begin
            ras_n <= 1'b0; // RULE_16
            cnt <= CNT_RAS;
            state <= DCRC_CBR_RAS;
          end
        end
        DCRC_CBR_SETUP:
        begin
          if (last)
          begin
            ras_n <= 1'b0; // RULE_10
            cnt <= CNT_RAS;
            state <= DCRC_CBR_RAS;
          end
        end
        DCRC_CBR_RAS:
        begin
          if (last)
          begin
            // column hold is covered by the whole ras pulse
            ras_n <= 1'b1; // RULE_09
            cas_n <= 1'b1;
            // precharge also spaces successive refresh column pulses
            cnt <= CNT_PRE; // RULE_12
            state <= DCRC_PRE;
          end
        end
        DCRC_PRE:
        begin
          if (last)
            state <= DCRC_IDLE;
        end
      endcase
    end
  end

  // response: data sampled while cas is still low
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rsp_valid <= 1'b0;
      rsp_data <= 1'b0;
    end
    else
    begin
      rsp_valid <= (state == DCRC_COL) && last;
      if ((state == DCRC_COL) && last && !is_write)
        rsp_data <= q_sync; // RULE_15
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pending_age <= 8'h00;
    else
      pending_age <= refresh_pending ? pending_age + 8'h01 : 8'h00;
  end

  refresh_served_a: assert property (@(posedge clk) // RULE_13
    disable iff (!reset_n) pending_age < 8'h20)
    else $error("refresh left pending too long");

  cbr_we_high_a: assert property (@(posedge clk) // RULE_10
    disable iff (!reset_n) ($fell(ras_n) && !cas_n) |->
    we_n && $past(we_n) ##1 we_n)
    else $error("write enable not high around refresh row fall");

  no_test_mode_a: assert property (@(posedge clk) // RULE_11
    disable iff (!reset_n) $fell(ras_n) |-> !($past(!we_n) && !cas_n))
    else $error("test mode entry produced");

  cbr_cas_setup_a: assert property (@(posedge clk) // RULE_09
    disable iff (!reset_n) ($fell(ras_n) && !cas_n) |->
    $past(!cas_n) ##1 !cas_n)
    else $error("refresh column strobe setup or hold broken");

  write_complete_a: assert property (@(posedge clk) // RULE_06
    disable iff (!reset_n) ($fell(cas_n) && !we_n) |->
    (!ras_n && !cas_n)[*2])
    else $error("strobes rose too soon after write");

  read_we_hold_a: assert property (@(posedge clk) // RULE_01
    disable iff (!reset_n) ($rose(cas_n) && $past(!ras_n) && $past(we_n))
    |-> we_n)
    else $error("write enable fell at end of read");

  col_addr_out_a: assert property (@(posedge clk) // RULE_14
    disable iff (!reset_n) ($fell(cas_n) && !ras_n) |->
    muxed_address_lines == col_addr)
    else $error("column address not on lines at column fall");

  ras_pulse_a: assert property (@(posedge clk) // RULE_14
    disable iff (!reset_n) $fell(ras_n) |-> !ras_n[*3])
    else $error("row strobe pulse too short");

  ras_precharge_a: assert property (@(posedge clk) // RULE_12
    disable iff (!reset_n) $rose(ras_n) |-> ras_n[*3])
    else $error("row strobe precharge too short");

  // the pulse is seen six edges after the column fall is seen
  read_rsp_a: assert property (@(posedge clk) // RULE_15
    disable iff (!reset_n) ($fell(cas_n) && !ras_n && we_n) |->
    ##6 rsp_valid)
    else $error("read response not on time");

  read_c: cover property (@(posedge clk) disable iff (!reset_n)
    rsp_valid && we_n);
  write_c: cover property (@(posedge clk) disable iff (!reset_n)
    $fell(cas_n) && !we_n);
  cbr_c: cover property (@(posedge clk) disable iff (!reset_n)
    state == DCRC_CBR_SETUP);
  hidden_c: cover property (@(posedge clk) disable iff (!reset_n)
    state == DCRC_HIDDEN_PRE);

endmodule
`default_nettype wire

// ### rtl/dcrc_refresh_timer.sv
// refresh timer: one-cycle tick at the row refresh spacing
// assumes clk at the package clock rate
`timescale 1ns/1ns
`default_nettype none
module dcrc_refresh_timer
  import dcrc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // refresh request
  output logic refresh_tick
);

  localparam logic [11:0] INTERVAL = 12'(REFRESH_INTERVAL_CYC - 1);

  logic [11:0] count;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count <= 12'h000;
      refresh_tick <= 1'b0;
    end
    else
    begin
      refresh_tick <= (count == INTERVAL);
      count <= (count == INTERVAL) ? 12'h000 : count + 12'h001;
    end
  end

  tick_spacing_a: assert property (@(posedge clk) // RULE_13
    disable iff (!reset_n) refresh_tick |=> !refresh_tick[*8])
    else $error("refresh ticks too close");

endmodule
`default_nettype wire
